// ---- serdes_eye_scan_pkg.sv ----
// Package for the eye-scan status and lane tuning block
// Assumes a byte-wide configuration register port with 10-bit byte addresses
package serdes_eye_scan_pkg;
  localparam int          NUM_LANES         = 16;
  localparam int          NUM_WIRED         = 2;
  localparam logic [3:0]  WIRED_LANE_A      = 4'h6;
  localparam logic [3:0]  WIRED_LANE_B      = 4'hE;
  localparam logic [9:0]  ADDR_CLEAR        = 10'h1F5;
  localparam logic [9:0]  ADDR_COMPLETE_LO  = 10'h1F6;
  localparam logic [9:0]  ADDR_COMPLETE_HI  = 10'h1F7;
  localparam logic [9:0]  ADDR_VOLT_BASE    = 10'h200;
  localparam logic [9:0]  ADDR_COUNT_BASE   = 10'h210;
  localparam logic [9:0]  ADDR_LOSS_TH      = 10'h234;
  localparam logic [9:0]  ADDR_VOTE_SIZE    = 10'h235;
  localparam logic [9:0]  ADDR_FREEZE       = 10'h238;
  localparam logic [7:0]  RESET_CLEAR       = 8'h00;
  localparam logic [7:0]  RESET_LOSS_TH     = 8'h08;
  localparam logic [7:0]  RESET_VOTE_SIZE   = 8'h00;
  localparam logic [7:0]  RESET_FREEZE      = 8'h00;
  localparam int          CLEAR_BIT         = 0;
  localparam int          FREEZE_BIT        = 0;
  localparam int          VOLT_WIDTH        = 6;
  localparam int          BITS_PER_WORD     = 20;
  localparam logic [4:0]  LAST_BIT_POS      = 5'h13;
  localparam logic [8:0]  VOTES_DEFAULT     = 9'h1FF;
  localparam logic [15:0] LEN_127           = 16'h007F;
  localparam logic [15:0] LEN_1032          = 16'h0408;
  localparam logic [15:0] LEN_8191          = 16'h1FFF;
  localparam logic [15:0] LEN_65535         = 16'hFFFF;

  typedef enum logic [3:0] {
    MODE_OFF         = 4'h0,
    MODE_COMPARE     = 4'h1,
    MODE_CMP_ZEROS   = 4'h2,
    MODE_CMP_ONES    = 4'h3,
    MODE_COUNT_ONES  = 4'h4,
    MODE_AVG_ZERO    = 4'h8,
    MODE_OUTER_ZERO  = 4'h9,
    MODE_INNER_ZERO  = 4'hA,
    MODE_AVG_ONE     = 4'hC,
    MODE_OUTER_ONE   = 4'hD,
    MODE_INNER_ONE   = 4'hE
  } scan_mode_e;
endpackage : serdes_eye_scan_pkg

// ---- serdes_eye_scan_results.sv ----
// Eye-scan engines for the wired lanes plus the shared lane tuning registers
// Assumes sampler bits arrive asynchronously on pins; scan setup comes from same-clock registers
`timescale 1ns/1ps
module serdes_eye_scan_results
  import serdes_eye_scan_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [9:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_write,
  output logic      [7:0]           reg_rdata,
  input  wire logic [3:0]           scan_mode_select,
  input  wire logic                 scan_run,
  input  wire logic [1:0]           scan_length,
  input  wire logic [4:0]           scan_bit_position,
  input  wire logic                 signal_loss_detect_enable,
  input  wire logic [NUM_WIRED-1:0] lane_data_bit,
  input  wire logic [NUM_WIRED-1:0] lane_scan_bit,
  input  wire logic [NUM_WIRED-1:0] lane_sample_valid,
  output logic      [7:0]           loss_threshold_mv,
  output logic      [8:0]           equalizer_vote_target,
  output logic                      recovery_freeze
);

  function automatic logic [8:0] vote_decode(input logic [3:0] code);
    logic [8:0] v;
    v = VOTES_DEFAULT;
    if (code >= 4'h2 && code <= 4'h9) begin
      v = 9'((10'h001 << (code - 4'h1)) - 10'h001);
    end
    return v;
  endfunction : vote_decode

  function automatic logic [15:0] length_decode(input logic [1:0] len);
    logic [15:0] n;
    case (len)
      2'h0:    n = LEN_127;
      2'h1:    n = LEN_1032;
      2'h2:    n = LEN_8191;
      default: n = LEN_65535;
    endcase
    return n;
  endfunction : length_decode

  logic [7:0]  error_counter_clear;
  logic [7:0]  signal_loss_threshold;
  logic [7:0]  equalizer_vote_size;
  logic [7:0]  freeze_reg;
  logic        scan_run_q;
  logic [NUM_WIRED-1:0] data_s1, data_s2, scan_s1, scan_s2, valid_s1, valid_s2;

  logic [NUM_WIRED-1:0]        wired_done;
  logic [15:0]                 wired_count [NUM_WIRED];
  logic [VOLT_WIDTH-1:0]       wired_volt  [NUM_WIRED];

  wire        clear_pulse = error_counter_clear[CLEAR_BIT] & reg_write & (reg_addr == ADDR_CLEAR)
                            & ~reg_wdata[CLEAR_BIT];
  wire        run_start   = scan_run & ~scan_run_q;
  wire [15:0] run_length  = length_decode(scan_length);
  wire        volt_mode   = scan_mode_select[3] & (scan_mode_select != 4'hB) & (scan_mode_select != 4'hF);
  wire        volt_target = scan_mode_select[2];

  // Shared configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      error_counter_clear   <= RESET_CLEAR;
      signal_loss_threshold <= RESET_LOSS_TH;
      equalizer_vote_size   <= RESET_VOTE_SIZE;
      freeze_reg            <= RESET_FREEZE;
    end else if (reg_write) begin
      if (reg_addr == ADDR_CLEAR) begin
        error_counter_clear <= reg_wdata;
      end else if (reg_addr == ADDR_LOSS_TH) begin
        signal_loss_threshold <= reg_wdata;
      end else if (reg_addr == ADDR_VOTE_SIZE) begin
        equalizer_vote_size <= reg_wdata;
      end else if (reg_addr == ADDR_FREEZE) begin
        freeze_reg <= reg_wdata;
      end
    end
  end

  // Decoded tuning outputs; reserved loss codes give no threshold
  wire [3:0] loss_code     = signal_loss_threshold[3:0];
  wire [7:0] next_loss_mv  = (signal_loss_detect_enable && loss_code >= 4'h2) ?
                             8'({4'h0, loss_code} * 8'h0F) : 8'h00;
  wire       next_freeze   = freeze_reg[FREEZE_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      loss_threshold_mv     <= 8'h00;
      equalizer_vote_target <= VOTES_DEFAULT;
      recovery_freeze       <= 1'b0;
      scan_run_q            <= 1'b0;
      data_s1               <= '0;
      data_s2               <= '0;
      scan_s1               <= '0;
      scan_s2               <= '0;
      valid_s1              <= '0;
      valid_s2              <= '0;
    end else begin
      loss_threshold_mv     <= next_loss_mv;
      equalizer_vote_target <= vote_decode(equalizer_vote_size[3:0]);
      recovery_freeze       <= next_freeze;
      scan_run_q            <= scan_run;
      data_s1               <= lane_data_bit;
      data_s2               <= data_s1;
      scan_s1               <= lane_scan_bit;
      scan_s2               <= scan_s1;
      valid_s1              <= lane_sample_valid;
      valid_s2              <= valid_s1;
    end
  end

  // One scan engine per wired lane
  genvar g;
  generate
    for (g = 0; g < NUM_WIRED; g++) begin : gen_lane
      logic [4:0]            bit_pos;
      logic [15:0]           analysed;
      logic [15:0]           scan_error_counter;
      logic [VOLT_WIDTH-1:0] volt;
      logic                  done;

      wire d = data_s2[g];
      wire s = scan_s2[g];
      wire at_pos     = valid_s2[g] & (bit_pos == scan_bit_position);
      wire active     = scan_run & ~done & (scan_mode_select != MODE_OFF) & ~run_start;
      wire considered = (scan_mode_select == MODE_CMP_ZEROS) ? ~d :
                        (scan_mode_select == MODE_CMP_ONES)  ?  d :
                        volt_mode ? (d == volt_target) : 1'b1;
      wire take       = active & at_pos & considered;
      wire hit        = (scan_mode_select == MODE_COMPARE || scan_mode_select == MODE_CMP_ZEROS ||
                         scan_mode_select == MODE_CMP_ONES) ? (s != d) :
                        (scan_mode_select == MODE_COUNT_ONES) ? s : 1'b0;
      wire volt_up    = s ^ ~volt_target;
      wire volt_max   = (volt == 6'h1F);
      wire volt_min   = (volt == 6'h20);
      wire [VOLT_WIDTH-1:0] next_volt = !(take && volt_mode) ? volt :
                                        (volt_up && !volt_max) ? volt + 6'h01 :
                                        (!volt_up && !volt_min) ? volt - 6'h01 : volt;
      wire [4:0] next_bit_pos = !valid_s2[g] ? bit_pos :
                                (bit_pos == LAST_BIT_POS) ? 5'h00 : bit_pos + 5'h01;

      always_ff @(posedge clk) begin
        if (rst) begin
          bit_pos            <= 5'h00;
          analysed           <= 16'h0000;
          scan_error_counter <= 16'h0000;
          volt               <= '0;
          done               <= 1'b0;
        end else begin
          bit_pos <= next_bit_pos;
          volt    <= run_start ? '0 : next_volt;
          if (run_start) begin
            done     <= 1'b0;
            analysed <= 16'h0000;
          end else if (take) begin
            analysed <= analysed + 16'h0001;
            done     <= (analysed + 16'h0001 == run_length);
          end
          if (clear_pulse) begin
            scan_error_counter <= 16'h0000;
          end else if (take && hit && scan_error_counter != 16'hFFFF) begin
            scan_error_counter <= scan_error_counter + 16'h0001;
          end
        end
      end

      assign wired_done[g]  = done;
      assign wired_count[g] = scan_error_counter;
      assign wired_volt[g]  = volt;
    end
  endgenerate

  // Map wired engines onto the sixteen physical lanes
  logic [NUM_LANES-1:0] lane_scan_complete;
  always_comb begin
    lane_scan_complete               = '0;
    lane_scan_complete[WIRED_LANE_A] = wired_done[0];
    lane_scan_complete[WIRED_LANE_B] = wired_done[1];
  end

  wire [9:0] volt_off   = reg_addr - ADDR_VOLT_BASE;
  wire [9:0] count_off  = reg_addr - ADDR_COUNT_BASE;
  wire [3:0] count_lane = count_off[4:1];
  wire       in_volt    = (reg_addr >= ADDR_VOLT_BASE) && (reg_addr < ADDR_COUNT_BASE);
  wire       in_count   = (reg_addr >= ADDR_COUNT_BASE) && (count_off < 10'h020);
  wire [15:0] sel_count = (count_lane == WIRED_LANE_A) ? wired_count[0] :
                          (count_lane == WIRED_LANE_B) ? wired_count[1] : 16'h0000;
  wire [7:0]  sel_volt  = (volt_off[3:0] == WIRED_LANE_A) ? {2'b00, wired_volt[0]} :
                          (volt_off[3:0] == WIRED_LANE_B) ? {2'b00, wired_volt[1]} : 8'h00;

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == ADDR_CLEAR) begin
      next_rdata = error_counter_clear;
    end else if (reg_addr == ADDR_COMPLETE_LO) begin
      next_rdata = lane_scan_complete[7:0];
    end else if (reg_addr == ADDR_COMPLETE_HI) begin
      next_rdata = lane_scan_complete[15:8];
    end else if (in_volt) begin
      next_rdata = sel_volt;
    end else if (in_count) begin
      next_rdata = count_off[0] ? sel_count[15:8] : sel_count[7:0];
    end else if (reg_addr == ADDR_LOSS_TH) begin
      next_rdata = signal_loss_threshold;
    end else if (reg_addr == ADDR_VOTE_SIZE) begin
      next_rdata = equalizer_vote_size;
    end else if (reg_addr == ADDR_FREEZE) begin
      next_rdata = freeze_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : serdes_eye_scan_results

// ---- serdes_eye_scan_results_asserts.sv ----
// Port checker for the eye-scan results block
// Assumes one clock with a synchronous active-high reset
`timescale 1ns/1ps
module serdes_eye_scan_results_sva
  import serdes_eye_scan_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic [7:0] reg_rdata,
  input wire logic       scan_run,
  input wire logic       signal_loss_detect_enable,
  input wire logic [7:0] loss_threshold_mv,
  input wire logic [8:0] equalizer_vote_target,
  input wire logic       recovery_freeze
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wr_freeze = reg_write && reg_addr == ADDR_FREEZE;
  wire wr_loss   = reg_write && reg_addr == ADDR_LOSS_TH;
  wire wr_vote   = reg_write && reg_addr == ADDR_VOTE_SIZE;
  function automatic logic [8:0] votes(input logic [3:0] c);
    return (c >= 4'h2 && c <= 4'h9) ? (9'h001 << (c - 4'h1)) - 9'h001 : VOTES_DEFAULT;
  endfunction : votes
  property p_freeze; wr_freeze |-> ##2 recovery_freeze == $past(reg_wdata[FREEZE_BIT], 2); endproperty
  a_freeze: assert property (p_freeze) else $error("freeze output wrong");
  property p_loss;
    (wr_loss && reg_wdata[3:0] >= 4'h2) ##1 signal_loss_detect_enable
      |=> loss_threshold_mv == 8'(15 * $past(reg_wdata[3:0], 2));
  endproperty
  a_loss: assert property (p_loss) else $error("loss threshold wrong");
  property p_loss_off; !signal_loss_detect_enable |=> loss_threshold_mv == 8'h00; endproperty
  a_loss_off: assert property (p_loss_off) else $error("loss threshold not zero");
  property p_vote; wr_vote |-> ##2 equalizer_vote_target == votes($past(reg_wdata[3:0], 2)); endproperty
  a_vote: assert property (p_vote) else $error("vote target wrong");
  property p_unwired_count; reg_addr >= ADDR_COUNT_BASE && reg_addr < 10'h21C |=> reg_rdata == 8'h00; endproperty
  a_unwired_count: assert property (p_unwired_count) else $error("unwired count not zero");
  property p_volt_top; reg_addr >= ADDR_VOLT_BASE && reg_addr < ADDR_COUNT_BASE |=> reg_rdata[7:6] == 2'b00; endproperty
  a_volt_top: assert property (p_volt_top) else $error("voltage result top bits set");
  property p_done_unwired; reg_addr == ADDR_COMPLETE_LO |=> (reg_rdata & 8'hBF) == 8'h00; endproperty
  a_done_unwired: assert property (p_done_unwired) else $error("unwired completion set");
  property p_run_clear; $rose(scan_run) ##1 reg_addr == ADDR_COMPLETE_LO |=> !reg_rdata[6]; endproperty
  a_run_clear: assert property (p_run_clear) else $error("completion not cleared");
  c_freeze: cover property (wr_freeze);
  c_done: cover property (reg_addr == ADDR_COMPLETE_LO ##1 reg_rdata[6]);
  c_run: cover property ($rose(scan_run));
endmodule : serdes_eye_scan_results_sva
bind serdes_eye_scan_results serdes_eye_scan_results_sva chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata), .scan_run(scan_run),
  .signal_loss_detect_enable(signal_loss_detect_enable), .loss_threshold_mv(loss_threshold_mv),
  .equalizer_vote_target(equalizer_vote_target), .recovery_freeze(recovery_freeze));

// ---- tb.sv ----
// Self-checking bench for the eye-scan results block
// Assumes the byte register port with registered read data
`timescale 1ns/1ps
module tb;
  import serdes_eye_scan_pkg::*;
  logic                 clk = 1'b0, rst = 1'b1, reg_write = 1'b0, scan_run = 1'b0, signal_loss_detect_enable = 1'b0;
  logic [9:0]           reg_addr = '0;
  logic [7:0]           reg_wdata = '0, reg_rdata, loss_threshold_mv, b;
  logic [3:0]           scan_mode_select = '0;
  logic [1:0]           scan_length = 2'h0;
  logic [4:0]           scan_bit_position = 5'h05;
  logic [NUM_WIRED-1:0] lane_data_bit = '0, lane_scan_bit = '0, lane_sample_valid = '0;
  logic [8:0]           equalizer_vote_target;
  logic                 recovery_freeze;
  logic [15:0]          v;
  int                   bad_count = 0, compares = 0, cycles = 0;
  logic [9:0]           ra [5] = '{ADDR_CLEAR, ADDR_LOSS_TH, ADDR_VOTE_SIZE, ADDR_FREEZE, 10'h300};
  logic [7:0]           rv [5] = '{RESET_CLEAR, RESET_LOSS_TH, RESET_VOTE_SIZE, RESET_FREEZE, 8'h00};
  serdes_eye_scan_results dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_rdata(reg_rdata), .scan_mode_select(scan_mode_select), .scan_run(scan_run),
    .scan_length(scan_length), .scan_bit_position(scan_bit_position),
    .signal_loss_detect_enable(signal_loss_detect_enable),
    .lane_data_bit(lane_data_bit), .lane_scan_bit(lane_scan_bit), .lane_sample_valid(lane_sample_valid),
    .loss_threshold_mv(loss_threshold_mv), .equalizer_vote_target(equalizer_vote_target),
    .recovery_freeze(recovery_freeze));
  initial forever #12.5 clk = ~clk;
  task automatic wrap_up;
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk); reg_addr = a; reg_wdata = d; reg_write = 1'b1;
    @(negedge clk); reg_write = 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk); reg_addr = a;
    @(negedge clk); d = reg_rdata;
  endtask : rd
  task automatic rd16(input logic [9:0] a, output logic [15:0] d);
    logic [7:0] lo, hi;
    rd(a, lo); rd(a + 10'h001, hi); d = {hi, lo};
  endtask : rd16
  task automatic run_scan(input logic [3:0] m, input logic [1:0] d, input logic [1:0] s, input logic [4:0] p);
    logic [7:0] lo, hi;
    int         n;
    @(negedge clk); scan_mode_select = m; lane_data_bit = d; lane_scan_bit = s; lane_sample_valid = '1; scan_run = 1'b0;
    scan_bit_position = p;
    @(negedge clk); scan_run = 1'b1;
    rd(ADDR_COMPLETE_LO, lo); chk(16'(lo), 16'h0000);
    n = 0; hi = '0;
    while (!(lo[6] === 1'b1 && hi[6] === 1'b1) && n < 2000) begin
      rd(ADDR_COMPLETE_LO, lo); rd(ADDR_COMPLETE_HI, hi); n++;
    end
    lane_sample_valid = '0;
    chk({hi, lo}, 16'h4040);
  endtask : run_scan
  initial begin
    repeat (8) @(negedge clk); rst = 1'b0;
    foreach (ra[i]) begin rd(ra[i], b); chk(16'(b), 16'(rv[i])); end
    chk(16'(equalizer_vote_target), 16'h01FF);
    wr(ADDR_COMPLETE_LO, 8'hFF); rd(ADDR_COMPLETE_LO, b); chk(16'(b), 16'h0000);
    signal_loss_detect_enable = 1'b1;
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_LOSS_TH, 8'(c)); wr(ADDR_VOTE_SIZE, 8'(c)); @(negedge clk);
      chk(16'(loss_threshold_mv), c >= 2 ? 16'(15 * c) : 16'h0000);
      chk(16'(equalizer_vote_target), (c >= 2 && c <= 9) ? 16'((1 << (c - 1)) - 1) : 16'h01FF);
    end
    rd(ADDR_VOTE_SIZE, b); chk(16'(b), 16'h000F);
    wr(ADDR_VOTE_SIZE, 8'h00);
    signal_loss_detect_enable = 1'b0; @(negedge clk); chk(16'(loss_threshold_mv), 16'h0000);
    wr(ADDR_FREEZE, 8'h01);
    @(negedge clk); chk(16'(recovery_freeze), 16'h0001);
    wr(ADDR_FREEZE, 8'h00); @(negedge clk); chk(16'(recovery_freeze), 16'h0000);
    run_scan(MODE_COMPARE, 2'b00, 2'b01, 5'h05);
    rd16(ADDR_COUNT_BASE + 10'h00C, v); chk(v, 16'h007F);
    rd16(ADDR_COUNT_BASE + 10'h01C, v); chk(v, 16'h0000);
    rd16(ADDR_COUNT_BASE, v); chk(v, 16'h0000);
    rd(ADDR_VOLT_BASE + 10'h006, b); chk(16'(b & 8'hC0), 16'h0000);
    rd(ADDR_VOLT_BASE, b); chk(16'(b), 16'h0000);
    wr(ADDR_CLEAR, 8'h01); wr(ADDR_CLEAR, 8'h00);
    rd16(ADDR_COUNT_BASE + 10'h00C, v); chk(v, 16'h0000);
    run_scan(MODE_CMP_ONES, 2'b11, 2'b10, 5'h05);
    rd16(ADDR_COUNT_BASE + 10'h00C, v); chk(v, 16'h007F);
    rd16(ADDR_COUNT_BASE + 10'h01C, v); chk(v, 16'h0000);
    run_scan(MODE_AVG_ONE, 2'b11, 2'b01, LAST_BIT_POS);
    rd(ADDR_VOLT_BASE + 10'h006, b); chk(16'(b), 16'h001F);
    rd(ADDR_VOLT_BASE + 10'h00E, b); chk(16'(b), 16'h0020);
    rd16(ADDR_COUNT_BASE + 10'h00C, v); chk(v, 16'h007F);
    wr(ADDR_CLEAR, 8'h01); wr(ADDR_CLEAR, 8'h00);
    run_scan(MODE_COUNT_ONES, 2'b10, 2'b01, 5'h00);
    rd16(ADDR_COUNT_BASE + 10'h00C, v); chk(v, 16'h007F);
    rd16(ADDR_COUNT_BASE + 10'h01C, v); chk(v, 16'h0000);
    wrap_up();
  end
endmodule : tb
